// ==== rtl/mdio_pkg.sv ====
// constants shared by the motion driver discrete i/o block
package mdio_pkg;
  // register byte offsets
  localparam logic [5:0] CTRL_OFS   = 6'h00;  // mode and polarity bits
  localparam logic [5:0] OUTSEL_OFS = 6'h04;  // function codes, port 1..4
  localparam logic [5:0] PRESET_OFS = 6'h08;  // preset position
  localparam logic [5:0] AREA1_OFS  = 6'h0C;  // zone boundary one
  localparam logic [5:0] AREA2_OFS  = 6'h10;  // zone boundary two
  localparam logic [5:0] SPDIX_OFS  = 6'h14;  // speed table index
  localparam logic [5:0] SPDDAT_OFS = 6'h18;  // speed table entry at index
  localparam logic [5:0] REMOTE_OFS = 6'h1C;  // remote outputs 1..4
  localparam logic [5:0] STATUS_OFS = 6'h20;  // read-only state
  localparam logic [5:0] POS_OFS    = 6'h24;  // read-only command position
  localparam logic [5:0] HSPD_OFS   = 6'h28;  // origin-seek speed
  // control field positions
  localparam int CTRL_PRESET_BIT = 0;  // 1: shared input loads preset
  localparam int CTRL_LSNC_BIT   = 1;  // limits normally closed
  localparam int CTRL_HOMNC_BIT  = 2;  // origin sensor normally closed
  localparam int CTRL_SLTNC_BIT  = 3;  // slit input normally closed
  localparam int CTRL_OT_BIT     = 4;  // overtravel detection enable
  localparam int CTRL_SLIT_BIT   = 5;  // slit detection enable
  // reset values
  localparam logic [5:0]  CTRL_RST   = 6'h00;   // origin-seek mode
  localparam logic [15:0] OUTSEL_RST = 16'h4320; // zone, ready, warn, origin
  localparam logic [15:0] HSPD_RST   = 16'h0100;
  localparam logic [15:0] ACCEL_STEP = 16'h0004; // speed change per cycle
  // assignable output function codes
  localparam logic [3:0] FN_ZONE = 4'h0;
  localparam logic [3:0] FN_TIM  = 4'h1;
  localparam logic [3:0] FN_RDY  = 4'h2;
  localparam logic [3:0] FN_WARN = 4'h3;
  localparam logic [3:0] FN_ORG  = 4'h4;
  localparam logic [3:0] FN_IDX  = 4'h5;
  localparam logic [3:0] FN_REM1 = 4'h6;
  localparam logic [3:0] FN_HEAT = 4'hA;
  localparam logic [3:0] FN_MISS = 4'hB;
  // motion states
  typedef enum logic [1:0] {ST_IDLE, ST_JOG, ST_STOP, ST_HOME} mdio_state_type;
endpackage : mdio_pkg

// ==== rtl/mdio_top.sv ====
// motion driver discrete i/o control with wishbone register access
// Notes on behaviour
// - jog inputs run motor in their direction
// - both jog inputs active: decelerate to stop
// - jog speed from selected data number
// - data number change retargets speed live
// - shared input mode chosen, resets to seek
// - rising edge starts origin seek
// - load mode copies preset into position
// - alarm stops motor, drops fault output
// - clear input falling edge clears alarm
// - fatal alarms stay until reset
// - negative limit: origin in seek, polarity shared
// - limits stop jogs only if enabled
// - origin sensor marks origin, polarity set
// - slit refines origin when enabled
// - motion output set; no start while set
// - motion output held while start held
// - four ports each pick one function
// - zone match whenever position in zone
// - equal boundaries: match exact position
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module mdio_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        forward_jog_in_i,
  input  wire logic        reverse_jog_in_i,
  input  wire logic        start_i,          // positioning start level
  input  wire logic        home_preset_i,    // shared seek / load input
  input  wire logic        fault_clear_in_i,
  input  wire logic [5:0]  data_select_bits_i,
  input  wire logic        positive_limit_in_i,
  input  wire logic        negative_limit_in_i,
  input  wire logic        origin_sensor_in_i,
  input  wire logic        slit_in_i,
  input  wire logic        alarm_i,          // resettable alarm event
  input  wire logic        fatal_alarm_i,    // non-resettable alarm event
  input  wire logic        warning_in_i,
  input  wire logic        overheat_in_i,
  input  wire logic        misstep_in_i,
  input  wire logic        excitation_home_i,
  input  wire logic        encoder_index_in_i,
  output logic             step_o,           // one pulse per position step
  output logic             dir_o,            // 1: negative direction
  output logic             move_o,
  output logic             fault_out_o,      // high when healthy
  output logic      [3:0]  assignable_port_o
);
  // registers
  logic [5:0]  ctrl_r;                 // mode and polarity bits
  logic [15:0] outsel_r;               // function code per port
  logic [31:0] preset_r;               // preset position
  logic [31:0] area1_r;                // zone boundary one
  logic [31:0] area2_r;                // zone boundary two
  logic [5:0]  spd_ix_r;               // table index for software
  logic [15:0] spd_tab_r [64];         // speed per data number
  logic [3:0]  remote_r;               // remote output bits
  logic [15:0] hspd_r;                 // origin-seek speed
  // motion state
  mdio_pkg::mdio_state_type state_r, state_nxt;
  logic [15:0] speed_r, speed_nxt;     // present speed
  logic [23:0] acc_r;                  // step phase accumulator
  logic [31:0] pos_r, pos_nxt;         // signed command position
  logic        dir_nxt;
  logic        alarm_r, fatal_r;       // latched alarm classes
  logic        home_set_r;             // origin established
  logic        clr_q_r, hp_q_r;        // previous input samples
  logic        zone_r;                 // zone match flag
  logic        ack_r;

  // byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      wmerge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
  endfunction : wmerge

  // inclusive zone test, order of bounds free
  function automatic logic in_zone(input logic [31:0] p, input logic [31:0] a,
                                   input logic [31:0] b);
    logic signed [31:0] lo;
    logic signed [31:0] hi;
    lo = ($signed(a) < $signed(b)) ? $signed(a) : $signed(b);
    hi = ($signed(a) < $signed(b)) ? $signed(b) : $signed(a);
    in_zone = ($signed(p) >= lo) && ($signed(p) <= hi);
  endfunction : in_zone

  // bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  wire bus_wr  = bus_req && wb_we_i;
  wire [31:0] wr_ctrl = wmerge({26'h0, ctrl_r}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_out  = wmerge({16'h0, outsel_r}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_spd  = wmerge({16'h0, spd_tab_r[spd_ix_r]}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_hspd = wmerge({16'h0, hspd_r}, wb_dat_i, wb_sel_i);
  // input qualification by polarity
  wire plim_act = positive_limit_in_i ^ ctrl_r[mdio_pkg::CTRL_LSNC_BIT];
  wire nlim_act = negative_limit_in_i ^ ctrl_r[mdio_pkg::CTRL_LSNC_BIT];
  wire org_act  = origin_sensor_in_i ^ ctrl_r[mdio_pkg::CTRL_HOMNC_BIT];
  wire slit_act = slit_in_i ^ ctrl_r[mdio_pkg::CTRL_SLTNC_BIT];
  wire slit_ok  = !ctrl_r[mdio_pkg::CTRL_SLIT_BIT] || slit_act;
  wire origin_hit = (org_act && slit_ok) || nlim_act;
  wire ot_en     = ctrl_r[mdio_pkg::CTRL_OT_BIT];
  wire ot_hit    = ot_en && (dir_o ? nlim_act : plim_act);
  // events
  wire clr_fall  = clr_q_r && !fault_clear_in_i;
  wire hp_rise   = home_preset_i && !hp_q_r;
  wire load_mode = ctrl_r[mdio_pkg::CTRL_PRESET_BIT];
  wire alarm_nxt = alarm_i || (alarm_r && !clr_fall);
  wire fatal_nxt = fatal_alarm_i || fatal_r;
  wire alarm_any = alarm_i || fatal_alarm_i || alarm_r || fatal_r;
  wire jog_any   = forward_jog_in_i || reverse_jog_in_i;
  wire jog_both  = forward_jog_in_i && reverse_jog_in_i;
  wire can_start = (state_r == mdio_pkg::ST_IDLE) && !move_o && !alarm_any;
  wire [15:0] jog_spd = spd_tab_r[data_select_bits_i];
  wire [24:0] acc_sum = {1'b0, acc_r} + {9'h000, speed_r};
  wire        step_now = acc_sum[24];
  wire moving_nxt = (state_nxt != mdio_pkg::ST_IDLE) || start_i;
  wire ready_nxt = (state_nxt == mdio_pkg::ST_IDLE) && !alarm_nxt && !fatal_nxt
                   && !jog_any && !start_i && !home_preset_i;
  wire org_reached = home_set_r && (pos_r == 32'h0000_0000)
                     && (state_r == mdio_pkg::ST_IDLE);
  wire [11:0] fn_val = {misstep_in_i, overheat_in_i, remote_r, encoder_index_in_i,
                        org_reached, warning_in_i, ready_nxt, excitation_home_i,
                        zone_r};

  // motion state machine and speed target
  always_comb
  begin
    state_nxt = state_r;
    speed_nxt = speed_r;
    dir_nxt   = dir_o;
    unique case (state_r)
      mdio_pkg::ST_IDLE:
      begin
        speed_nxt = 16'h0000;
        if (can_start && jog_any && !jog_both)
        begin
          state_nxt = mdio_pkg::ST_JOG;
          dir_nxt   = reverse_jog_in_i;
        end
        else if (can_start && hp_rise && !load_mode)
        begin
          state_nxt = mdio_pkg::ST_HOME;
          dir_nxt   = 1'b1;
        end
      end
      mdio_pkg::ST_JOG:
      begin
        if (jog_both || !jog_any)
          state_nxt = mdio_pkg::ST_STOP;
        else if (ot_hit)
        begin
          state_nxt = mdio_pkg::ST_IDLE;
          speed_nxt = 16'h0000;
        end
        else if (speed_r < jog_spd)
          speed_nxt = (jog_spd - speed_r > mdio_pkg::ACCEL_STEP) ?
                      speed_r + mdio_pkg::ACCEL_STEP : jog_spd;
        else
          speed_nxt = (speed_r - jog_spd > mdio_pkg::ACCEL_STEP) ?
                      speed_r - mdio_pkg::ACCEL_STEP : jog_spd;
      end
      mdio_pkg::ST_STOP:
      begin
        speed_nxt = (speed_r > mdio_pkg::ACCEL_STEP) ?
                    speed_r - mdio_pkg::ACCEL_STEP : 16'h0000;
        if (speed_r == 16'h0000)
          state_nxt = mdio_pkg::ST_IDLE;
      end
      mdio_pkg::ST_HOME:
      begin
        speed_nxt = hspd_r;
        if (origin_hit)
        begin
          state_nxt = mdio_pkg::ST_IDLE;
          speed_nxt = 16'h0000;
        end
      end
    endcase
    if (alarm_any)
    begin
      state_nxt = mdio_pkg::ST_IDLE;
      speed_nxt = 16'h0000;
    end
  end

  // position: origin clears, load copies preset, else steps
  always_comb
  begin
    pos_nxt = pos_r;
    if (state_r == mdio_pkg::ST_HOME && origin_hit)
      pos_nxt = 32'h0000_0000;
    else if (hp_rise && load_mode)
      pos_nxt = preset_r;
    else if (step_now)
      pos_nxt = dir_o ? pos_r - 32'h0000_0001 : pos_r + 32'h0000_0001;
  end

  // motion registers and alarm latches
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= mdio_pkg::ST_IDLE;
      speed_r <= 16'h0000;
      acc_r   <= 24'h00_0000;
      pos_r   <= 32'h0000_0000;
      dir_o   <= 1'b0;
      step_o  <= 1'b0;
      alarm_r <= 1'b0;
      fatal_r <= 1'b0;
      home_set_r  <= 1'b0;
      clr_q_r     <= 1'b0;
      hp_q_r      <= 1'b0;
      move_o      <= 1'b0;
      fault_out_o <= 1'b1;
      zone_r      <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      speed_r <= speed_nxt;
      acc_r   <= acc_sum[23:0];
      pos_r   <= pos_nxt;
      dir_o   <= dir_nxt;
      step_o  <= step_now;
      alarm_r <= alarm_nxt;
      fatal_r <= fatal_nxt;
      home_set_r  <= home_set_r || (state_r == mdio_pkg::ST_HOME && origin_hit)
                     || (hp_rise && load_mode);
      clr_q_r     <= fault_clear_in_i;
      hp_q_r      <= home_preset_i;
      move_o      <= moving_nxt;
      fault_out_o <= !(alarm_nxt || fatal_nxt);
      zone_r      <= in_zone(pos_r, area1_r, area2_r);
    end
  end

  // assignable ports select one status function each
  always_ff @(posedge clk_i)
  begin
    for (int k = 0; k < 4; k++)
      if (rst_i)
        assignable_port_o[k] <= 1'b0;
      else if (outsel_r[4*k +: 4] <= mdio_pkg::FN_MISS)
        assignable_port_o[k] <= fn_val[outsel_r[4*k +: 4]];
      else
        assignable_port_o[k] <= 1'b0;
  end

  // register writes and bus acknowledge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r   <= mdio_pkg::CTRL_RST;
      outsel_r <= mdio_pkg::OUTSEL_RST;
      preset_r <= 32'h0000_0000;
      area1_r  <= 32'h0000_0000;
      area2_r  <= 32'h0000_0000;
      spd_ix_r <= 6'h00;
      remote_r <= 4'h0;
      hspd_r   <= mdio_pkg::HSPD_RST;
      ack_r    <= 1'b0;
      for (int j = 0; j < 64; j++)
        spd_tab_r[j] <= 16'h0000;
    end
    else
    begin
      ack_r <= bus_req;
      if (bus_wr)
        unique case (wb_adr_i)
          mdio_pkg::CTRL_OFS:   ctrl_r   <= wr_ctrl[5:0];
          mdio_pkg::OUTSEL_OFS: outsel_r <= wr_out[15:0];
          mdio_pkg::PRESET_OFS: preset_r <= wmerge(preset_r, wb_dat_i, wb_sel_i);
          mdio_pkg::AREA1_OFS:  area1_r  <= wmerge(area1_r, wb_dat_i, wb_sel_i);
          mdio_pkg::AREA2_OFS:  area2_r  <= wmerge(area2_r, wb_dat_i, wb_sel_i);
          mdio_pkg::SPDIX_OFS:  if (wb_sel_i[0]) spd_ix_r <= wb_dat_i[5:0];
          mdio_pkg::SPDDAT_OFS: spd_tab_r[spd_ix_r] <= wr_spd[15:0];
          mdio_pkg::REMOTE_OFS: if (wb_sel_i[0]) remote_r <= wb_dat_i[3:0];
          mdio_pkg::HSPD_OFS:   hspd_r <= wr_hspd[15:0];
          default:              ;
        endcase
    end
  end

  // read data mux, unmapped reads return zero
  wire [31:0] status_w = {22'h0, state_r, zone_r, home_set_r, fatal_r, alarm_r,
                          fault_out_o, move_o, step_o, dir_o};
  wire [31:0] rd_mux =
    (wb_adr_i == mdio_pkg::CTRL_OFS)   ? {26'h0, ctrl_r} :
    (wb_adr_i == mdio_pkg::OUTSEL_OFS) ? {16'h0, outsel_r} :
    (wb_adr_i == mdio_pkg::PRESET_OFS) ? preset_r :
    (wb_adr_i == mdio_pkg::AREA1_OFS)  ? area1_r :
    (wb_adr_i == mdio_pkg::AREA2_OFS)  ? area2_r :
    (wb_adr_i == mdio_pkg::SPDIX_OFS)  ? {26'h0, spd_ix_r} :
    (wb_adr_i == mdio_pkg::SPDDAT_OFS) ? {16'h0, spd_tab_r[spd_ix_r]} :
    (wb_adr_i == mdio_pkg::REMOTE_OFS) ? {28'h0, remote_r} :
    (wb_adr_i == mdio_pkg::STATUS_OFS) ? status_w :
    (wb_adr_i == mdio_pkg::POS_OFS)    ? pos_r :
    (wb_adr_i == mdio_pkg::HSPD_OFS)   ? {16'h0, hspd_r} : 32'h0000_0000;

  // registered read data and ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_dat_o <= bus_req ? rd_mux : 32'h0000_0000;
      wb_ack_o <= bus_req;
    end
  end

  // cycles spent in the stop state, bounds the release ramp for the checks
  logic [14:0] stop_cnt_r;
  always_ff @(posedge clk_i)
    stop_cnt_r <= (rst_i || state_r != mdio_pkg::ST_STOP) ? 15'h0000 : stop_cnt_r + 15'h0001;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_jog_release;
    state_r == mdio_pkg::ST_JOG && !jog_any && !alarm_any ##1 state_r == mdio_pkg::ST_STOP;
  endsequence

  a_jog_start: assert property (can_start && forward_jog_in_i && !reverse_jog_in_i
    |=> state_r == mdio_pkg::ST_JOG && !dir_o) else $error("jog did not start");
  a_both_jog: assert property (state_r == mdio_pkg::ST_JOG && jog_both && !alarm_any
    |=> state_r == mdio_pkg::ST_STOP) else $error("both jogs not stopping");
  a_jog_speed: assert property (state_r == mdio_pkg::ST_JOG && state_nxt == mdio_pkg::ST_JOG
    && speed_r == jog_spd |=> speed_r == $past(jog_spd)) else $error("speed off");
  a_home_start: assert property (can_start && hp_rise && !load_mode && !jog_any
    |=> state_r == mdio_pkg::ST_HOME) else $error("seek not started");
  a_preset_load: assert property (hp_rise && load_mode && state_r == mdio_pkg::ST_IDLE
    |=> pos_r == $past(preset_r)) else $error("preset not loaded");
  a_alarm_stop: assert property (alarm_i |=> !fault_out_o && speed_r == 16'h0000
    && state_r == mdio_pkg::ST_IDLE) else $error("alarm did not stop");
  a_clear_edge: assert property (clr_fall && !alarm_i && !fatal_alarm_i && !fatal_r
    |=> fault_out_o && !alarm_r) else $error("alarm not cleared");
  a_fatal_hold: assert property (fatal_r |=> fatal_r ##1 !fault_out_o)
    else $error("fatal alarm lost");
  a_ot_stop: assert property (state_r == mdio_pkg::ST_JOG && ot_hit && jog_any && !jog_both
    |=> state_r == mdio_pkg::ST_IDLE) else $error("overtravel ignored");
  a_move_refuse: assert property (state_r == mdio_pkg::ST_IDLE && move_o
    |=> state_r == mdio_pkg::ST_IDLE) else $error("start while moving");
  a_start_hold: assert property (start_i |=> move_o) else $error("motion dropped");
  a_zone_exact: assert property (area1_r == area2_r && $stable(area1_r)
    |=> zone_r == ($past(pos_r) == $past(area1_r))) else $error("zone exact wrong");
  a_release_decel: assert property (s_jog_release |=> speed_r == 16'h0000
    || speed_r < $past(speed_r)) else $error("release not decelerating");
  a_stop_bound: assert property (stop_cnt_r <= 15'h4000) else $error("stop ramp too long");
endmodule : mdio_top

// ==== test/mdio_host_model.sv ====
// host controller model that drives the jog and shared seek or load inputs
`timescale 1ns/1ps
module mdio_host_model (
  input  wire logic clk_i,               // bench clock
  input  wire logic fault_out_i,         // high while the drive is healthy
  input  wire logic move_i,              // motion active from the drive
  input  wire logic fwd_cmd_i,           // bench wants a forward jog
  input  wire logic rvs_cmd_i,           // bench wants a reverse jog
  input  wire logic load_cmd_i,          // bench wants a preset load
  input  wire logic seek_cmd_i,          // bench wants an origin seek
  output logic      forward_jog_o = 1'b0, // forward jog level
  output logic      reverse_jog_o = 1'b0, // reverse jog level
  output logic      home_preset_o = 1'b0  // shared seek or load level
);
  // commands change just after the edge, jogs and seek withheld while the drive reports a fault, load withheld while motion is active
  always @(posedge clk_i)
  begin
    forward_jog_o <= fwd_cmd_i & fault_out_i;
    reverse_jog_o <= rvs_cmd_i & fault_out_i;
    home_preset_o <= (load_cmd_i & ~move_i) | (seek_cmd_i & fault_out_i);
  end
endmodule : mdio_host_model

// ==== test/motion_driver_io_control_test.sv ====
// self-checking bench for the motion driver discrete i/o block
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("mismatch at %0t: %s", $time, m); end end
module motion_driver_io_control_test;
  logic        clk_i = 1'b0, rst_i = 1'b1;          // clock and reset
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;   // bus request
  logic [5:0]  adr = 6'h0, dsel = 6'h0;             // bus address, data select
  logic [3:0]  sel = 4'h0, misc = 4'h0;             // lanes; exc, idx, heat, miss
  logic [31:0] dat = 32'h0, q_dat;                  // bus data out and in
  logic        start = 1'b0, fclr = 1'b0, lsp = 1'b0, lsn = 1'b0, org = 1'b0;
  logic        slit = 1'b0, fault_out = 1'b0, fatal = 1'b0, warn = 1'b0;
  logic        fwd_c = 1'b0, rvs_c = 1'b0, load_c = 1'b0, seek_c = 1'b0;
  logic        ack, step, dir, move, fault, forward_jog_in, reverse_jog_in, hp;  // drive and host model outputs
  logic [3:0]  port;                                // assignable outputs
  int          fail_count = 0, n_tests = 0, steps = 0;
  // free-running clock
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  // count step pulses
  always @(posedge clk_i) if (step === 1'b1) steps++;
  mdio_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q_dat), .wb_ack_o(ack),
    .forward_jog_in_i(forward_jog_in), .reverse_jog_in_i(reverse_jog_in), .start_i(start), .home_preset_i(hp),
    .fault_clear_in_i(fclr), .data_select_bits_i(dsel), .positive_limit_in_i(lsp),
    .negative_limit_in_i(lsn), .origin_sensor_in_i(org), .slit_in_i(slit), .alarm_i(fault_out),
    .fatal_alarm_i(fatal), .warning_in_i(warn), .overheat_in_i(misc[2]),
    .misstep_in_i(misc[3]), .excitation_home_i(misc[0]), .encoder_index_in_i(misc[1]),
    .step_o(step), .dir_o(dir), .move_o(move), .fault_out_o(fault), .assignable_port_o(port));
  mdio_host_model host (.clk_i(clk_i), .fault_out_i(fault), .move_i(move), .fwd_cmd_i(fwd_c),
    .rvs_cmd_i(rvs_c), .load_cmd_i(load_c), .seek_cmd_i(seek_c), .forward_jog_o(forward_jog_in),
    .reverse_jog_o(reverse_jog_in), .home_preset_o(hp));
  // one classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
    for (i = 0; i < 50 && ack !== 1'b1; i++) @(posedge clk_i);
    q = q_dat;
    {cyc, stb, we} <= 3'b000;
    `CHK(i < 50, 1'b1, "bus answer timeout")
  endtask : wb
  // register write
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  // register read compared under a mask
  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `CHK(q & m, e, "register read")
  endtask : rd
  // wait for the motion output to reach a level
  task automatic wait_move(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && move !== v; i++) @(posedge clk_i);
    `CHK(move, v, "motion output level")
  endtask : wait_move
  // settle the ramp, then count steps over 8192 cycles
  task automatic rate(output int n);
    int s0;
    repeat (4200) @(posedge clk_i);
    s0 = steps;
    repeat (8192) @(posedge clk_i);
    n = steps - s0;
  endtask : rate
  // load a preset through the shared input
  task automatic load(input logic [31:0] v);
    wr(mdio_pkg::PRESET_OFS, v);
    load_c <= 1'b1;
    repeat (3) @(posedge clk_i);
    load_c <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : load
  // synchronous reset for six cycles
  task automatic reset_dut;
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : reset_dut
  // reset values and start level holding motion
  task automatic t_reset;
    rd(mdio_pkg::CTRL_OFS, 32'h3F, 32'h0);
    rd(mdio_pkg::OUTSEL_OFS, 32'hFFFF, 32'h4320);
    rd(6'h3C, 32'hFFFFFFFF, 32'h0);
    `CHK(fault, 1'b1, "fault level after reset")
    `CHK(port[1], 1'b1, "ready on port two")
    start <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(move, 1'b1, "start level holds motion")
    start <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(move, 1'b0, "motion released")
    $display("test reset done");
  endtask : t_reset
  // forward jog, live speed change, release
  task automatic t_jog;
    int n;
    wr(mdio_pkg::SPDIX_OFS, 32'h3);
    wr(mdio_pkg::SPDDAT_OFS, 32'h4000);
    wr(mdio_pkg::SPDIX_OFS, 32'h5);
    wr(mdio_pkg::SPDDAT_OFS, 32'h8000);
    dsel <= 6'h3;
    fwd_c <= 1'b1;
    wait_move(1'b1, 6);
    rate(n);
    `CHK(dir, 1'b0, "forward direction")
    `CHK(n >= 7 && n <= 9, 1'b1, "step rate of entry three")
    dsel <= 6'h5;
    rate(n);
    `CHK(n >= 15 && n <= 17, 1'b1, "step rate of entry five")
    `CHK(move, 1'b1, "no stop on speed change")
    fwd_c <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(mdio_pkg::STATUS_OFS, 32'h300, 32'h200);
    wait_move(1'b0, 10000);
    $display("test jog done");
  endtask : t_jog
  // reverse jog, then both jogs together
  task automatic t_rev;
    dsel <= 6'h3;
    rvs_c <= 1'b1;
    wait_move(1'b1, 6);
    repeat (2) @(posedge clk_i);
    `CHK(dir, 1'b1, "reverse direction")
    fwd_c <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(mdio_pkg::STATUS_OFS, 32'h300, 32'h200);
    {fwd_c, rvs_c} <= 2'b00;
    wait_move(1'b0, 10000);
    $display("test reverse done");
  endtask : t_rev
  // limits ignored unless overtravel on, polarity shared
  task automatic t_limit;
    fwd_c <= 1'b1;
    wait_move(1'b1, 6);
    lsp <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK(move, 1'b1, "limit ignored without overtravel")
    fwd_c <= 1'b0;
    wait_move(1'b0, 10000);
    wr(mdio_pkg::CTRL_OFS, 32'h12);
    fwd_c <= 1'b1;
    {lsp, lsn} <= 2'b11;
    wait_move(1'b1, 6);
    lsp <= 1'b0;
    wait_move(1'b0, 4);
    fwd_c <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(mdio_pkg::CTRL_OFS, 32'h0);
    {lsp, lsn} <= 2'b00;
    $display("test limits done");
  endtask : t_limit
  // origin seek by sensor, jog refused meanwhile, seek by negative limit
  task automatic t_seek;
    wr(mdio_pkg::CTRL_OFS, 32'h4);
    org <= 1'b1;
    seek_c <= 1'b1;
    wait_move(1'b1, 6);
    fwd_c <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(mdio_pkg::STATUS_OFS, 32'h301, 32'h301);
    {fwd_c, seek_c} <= 2'b00;
    repeat (2) @(posedge clk_i);
    org <= 1'b0;
    wait_move(1'b0, 8);
    rd(mdio_pkg::POS_OFS, 32'hFFFFFFFF, 32'h0);
    rd(mdio_pkg::STATUS_OFS, 32'h40, 32'h40);
    `CHK(port[3], 1'b1, "origin reached on port four")
    wr(mdio_pkg::CTRL_OFS, 32'h0);
    seek_c <= 1'b1;
    wait_move(1'b1, 6);
    seek_c <= 1'b0;
    lsn <= 1'b1;
    wait_move(1'b0, 8);
    lsn <= 1'b0;
    wr(mdio_pkg::CTRL_OFS, 32'h20);
    {org, seek_c} <= 2'b11;
    wait_move(1'b1, 6);
    seek_c <= 1'b0;
    repeat (6) @(posedge clk_i);
    `CHK(move, 1'b1, "origin waits for slit")
    slit <= 1'b1;
    wait_move(1'b0, 8);
    {org, slit} <= 2'b00;
    $display("test seek done");
  endtask : t_seek
  // preset loading and zone match
  task automatic t_zone;
    wr(mdio_pkg::CTRL_OFS, 32'h1);
    wr(mdio_pkg::AREA1_OFS, 32'h10);
    wr(mdio_pkg::AREA2_OFS, 32'h10);
    load(32'h10);
    `CHK(move, 1'b0, "load mode starts no seek")
    `CHK(port[0], 1'b1, "zone match at single point")
    rd(mdio_pkg::POS_OFS, 32'hFFFFFFFF, 32'h10);
    load(32'h11);
    `CHK(port[0], 1'b0, "zone miss beside single point")
    wr(mdio_pkg::AREA1_OFS, 32'h20);
    repeat (3) @(posedge clk_i);
    `CHK(port[0], 1'b1, "zone match inside")
    load(32'h21);
    `CHK(port[0], 1'b0, "zone miss outside")
    $display("test zone done");
  endtask : t_zone
  // function selection of the assignable ports
  task automatic t_ports;
    logic [3:0] codes [4] = '{4'h1, 4'h5, 4'hA, 4'hB};
    for (int k = 0; k < 4; k++)
    begin
      wr(mdio_pkg::OUTSEL_OFS, {28'h0, codes[k]});
      misc <= 4'h1 << k;
      repeat (3) @(posedge clk_i);
      `CHK(port[0], 1'b1, "selected status high")
      misc <= 4'h0;
      repeat (3) @(posedge clk_i);
      `CHK(port[0], 1'b0, "selected status low")
    end
    wr(mdio_pkg::REMOTE_OFS, 32'h5);
    wr(mdio_pkg::OUTSEL_OFS, 32'h9876);
    repeat (3) @(posedge clk_i);
    `CHK(port, 4'h5, "remote outputs")
    wr(mdio_pkg::OUTSEL_OFS, 32'hCCCC);
    repeat (3) @(posedge clk_i);
    `CHK(port, 4'h0, "unused codes drive low")
    $display("test ports done");
  endtask : t_ports
  // resettable and fatal alarms
  task automatic t_alarm;
    fwd_c <= 1'b1;
    wait_move(1'b1, 6);
    fault_out <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(fault, 1'b0, "alarm drops fault")
    fault_out <= 1'b0;
    wait_move(1'b0, 10000);
    {fwd_c, fclr} <= 2'b01;
    repeat (3) @(posedge clk_i);
    `CHK(fault, 1'b0, "clear waits for falling edge")
    fclr <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(fault, 1'b1, "clear on falling edge")
    fatal <= 1'b1;
    @(posedge clk_i);
    {fatal, fclr} <= 2'b01;
    repeat (3) @(posedge clk_i);
    fclr <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK(fault, 1'b0, "fatal alarm survives clear")
    reset_dut;
    @(posedge clk_i);
    `CHK(fault, 1'b1, "reset clears fatal alarm")
    $display("test alarm done");
  endtask : t_alarm
  // print counts and verdict, then stop
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // main sequence
  initial
  begin
    reset_dut;
    t_reset;
    t_jog;
    t_rev;
    t_limit;
    t_seek;
    t_zone;
    t_ports;
    t_alarm;
    print_verdict;
  end
  // watchdog, about two and a half times the expected run
  initial
  begin
    #900000;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule : motion_driver_io_control_test
